// [include/tdc_pkg.sv]
// Package for the triple down-counter timer block
package tdc_pkg;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned NUM_TMR    = 3;
  localparam int unsigned ADDR_W     = 8;
  // Address fields: timer index and register offset within a timer
  localparam int unsigned IDX_HI     = 6;
  localparam int unsigned IDX_LO     = 5;
  localparam int unsigned OFS_HI     = 4;
  // Register byte offsets, per timer stride
  localparam logic [7:0] OFS_LOAD    = 8'h00;
  localparam logic [7:0] OFS_VALUE   = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_CLEAR   = 8'h0C;
  localparam logic [7:0] TMR_STRIDE  = 8'h20;
  localparam logic [7:0] OFS_INT_ST  = 8'h60;
  localparam logic [7:0] OFS_INT_MSK = 8'h64;
  // Control register fields
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_MODE  = 1;
  localparam logic [CNT_W-1:0] CNT_WRAP = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
  // Tick source rates: selectable sources in kHz, fixed source in Hz
  localparam int unsigned TICK_FAST_KHZ = 508;
  localparam int unsigned TICK_SLOW_KHZ = 2;
  localparam int unsigned TICK_FIX_HZ   = 7372800;

  typedef enum logic [1:0] {
    TDC_FREE   = 2'b01,
    TDC_PERIOD = 2'b10
  } tdc_mode_t;

  typedef struct packed {
    logic             en;
    logic             periodic;
    logic [CNT_W-1:0] load;
    logic [CNT_W-1:0] count;
  } tdc_tmr_t;
endpackage : tdc_pkg

// [hw/tdc_timers.sv]
// Three 16-bit down-counting timers with APB registers and interrupt
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// R1: Three independent timers, each free-running or periodic reload mode.
// R2: Each timer has load, value, control and clear registers.
// R3: Timers one and two tick on a selectable 508 kHz or 2 kHz source.
// R4: Tick source and mode for timers one and two arrive as inputs.
// R5: Each timer has a readable, writable 16-bit data register and control.
// R6: A data register write loads the counter at once.
// R7: After a load the counter drops on the next active tick, then every tick.
// R8: Underflow raises that timer's interrupt in the same cycle.
// R9: Timer three ticks only on a fixed 7.3728 MHz source.
// R10: Timer three counts only when enabled and written, from next tick.
// R11: Free-running underflow wraps to 0xFFFF and keeps counting.
// R12: Periodic underflow reloads the last written value and continues.
// R13: Any write to a clear register drops that timer's pending interrupt.
// R14: Value reads return live count; load reads return last written value.
// R15: Tick edges are synchronised; counting only on edge while enabled.
module tdc_timers
  import tdc_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              tick_508k,
  input  wire logic              tick_2k,
  input  wire logic              tick_7m,
  input  wire logic              first_slow_timer_sel_slow,
  input  wire logic              first_slow_timer_periodic,
  input  wire logic              second_slow_timer_sel_slow,
  input  wire logic              second_slow_timer_periodic,
  output logic [NUM_TMR-1:0]     tmr_irq,
  output logic                   irq
);
  // Refuse a synchroniser too short to settle the tick pins
  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Tick synchronisers: first stage read only by second
  logic [SYNC_STAGES-1:0] sync_508k, sync_2k, sync_7m;
  logic                   last_508k, last_2k, last_7m;
  logic                   edge_508k, edge_2k, edge_7m;
  logic [SYNC_STAGES-1:0] next_sync_508k, next_sync_2k, next_sync_7m;
  logic                   next_last_508k, next_last_2k, next_last_7m;
  always_comb
  begin
    next_sync_508k = {sync_508k[SYNC_STAGES-2:0], tick_508k}; // R15
    next_sync_2k   = {sync_2k[SYNC_STAGES-2:0], tick_2k};
    next_sync_7m   = {sync_7m[SYNC_STAGES-2:0], tick_7m};
    next_last_508k = sync_508k[SYNC_STAGES-1];
    next_last_2k   = sync_2k[SYNC_STAGES-1];
    next_last_7m   = sync_7m[SYNC_STAGES-1];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_508k <= '0;
      sync_2k   <= '0;
      sync_7m   <= '0;
      last_508k <= 1'b0;
      last_2k   <= 1'b0;
      last_7m   <= 1'b0;
    end
    else
    begin
      sync_508k <= next_sync_508k;
      sync_2k   <= next_sync_2k;
      sync_7m   <= next_sync_7m;
      last_508k <= next_last_508k;
      last_2k   <= next_last_2k;
      last_7m   <= next_last_7m;
    end
  end
  assign edge_508k = sync_508k[SYNC_STAGES-1] & ~last_508k;
  assign edge_2k   = sync_2k[SYNC_STAGES-1] & ~last_2k;
  assign edge_7m   = sync_7m[SYNC_STAGES-1] & ~last_7m;

  // Per-timer tick and mode selection
  tdc_tmr_t           tmr [NUM_TMR];
  tdc_tmr_t           next_tmr [NUM_TMR];
  logic [NUM_TMR-1:0] tick;
  logic [NUM_TMR-1:0] mode_periodic;
  assign tick[0] = first_slow_timer_sel_slow  ? edge_2k : edge_508k;  // R3 R4
  assign tick[1] = second_slow_timer_sel_slow ? edge_2k : edge_508k;  // R3 R4
  assign tick[2] = edge_7m;                                           // R9
  assign mode_periodic[0] = first_slow_timer_periodic;                // R4
  assign mode_periodic[1] = second_slow_timer_periodic;
  assign mode_periodic[2] = tmr[2].periodic;

  // APB decode
  logic       wr_en;
  logic [1:0] sel_idx;
  logic [7:0] sel_ofs;
  assign wr_en   = psel & penable & pwrite;
  assign sel_idx = paddr[IDX_HI:IDX_LO];
  assign sel_ofs = 8'(paddr[OFS_HI:0]);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  logic [NUM_TMR-1:0] int_st, next_int_st;
  logic [NUM_TMR-1:0] int_msk, next_int_msk;
  logic [NUM_TMR-1:0] armed, next_armed;
  logic [NUM_TMR-1:0] underflow;

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++)                                    // R1
    begin : g_tmr
      logic hit;
      assign hit = (sel_idx == 2'(g)) && (paddr < OFS_INT_ST);
      assign underflow[g] = tick[g] & tmr[g].en & armed[g]
                          & (tmr[g].count == CNT_ZERO);              // R15
      always_comb
      begin
        next_tmr[g]   = tmr[g];
        next_armed[g] = armed[g];
        if (tick[g] && tmr[g].en && armed[g])                      // R7 R10
        begin
          if (tmr[g].count != CNT_ZERO)
            next_tmr[g].count = tmr[g].count - 16'h0001;
          else if (mode_periodic[g])
            next_tmr[g].count = tmr[g].load;                         // R12
          else
            next_tmr[g].count = CNT_WRAP;                            // R11
        end
        if (wr_en && hit && sel_ofs == OFS_LOAD)
        begin
          next_tmr[g].load  = pwdata[CNT_W-1:0];                     // R5
          next_tmr[g].count = pwdata[CNT_W-1:0];                     // R6
          next_armed[g]     = 1'b1;                                  // R10
        end
        if (wr_en && hit && sel_ofs == OFS_CTRL)
        begin
          next_tmr[g].en       = pwdata[CTRL_EN];                    // R2
          next_tmr[g].periodic = pwdata[CTRL_MODE];
        end
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tmr[g]   <= '0;
          armed[g] <= 1'b0;
        end
        else
        begin
          tmr[g]   <= next_tmr[g];
          armed[g] <= next_armed[g];
        end
      end
      always_comb
      begin
        next_int_st[g] = int_st[g];
        if (wr_en && hit && sel_ofs == OFS_CLEAR)
          next_int_st[g] = 1'b0;                                     // R13
        if (wr_en && paddr == OFS_INT_ST && pwdata[g])
          next_int_st[g] = 1'b0;
        if (underflow[g])
          next_int_st[g] = 1'b1;                                     // R8
      end
      // Underflow shows on the timer line in the same cycle
      assign tmr_irq[g] = underflow[g] | int_st[g];                  // R8
    end
  endgenerate

  // Interrupt mask register
  always_comb
  begin
    next_int_msk = int_msk;
    if (wr_en && paddr == OFS_INT_MSK)
      next_int_msk = pwdata[NUM_TMR-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_st  <= '0;
      int_msk <= '0;
    end
    else
    begin
      int_st  <= next_int_st;
      int_msk <= next_int_msk;
    end
  end
  assign irq = |(int_st & int_msk);

  // Read mux, combinational whenever psel is high for a read, setup phase included
  always_comb
  begin
    prdata = RD_ZERO;
    if (psel && !pwrite)
    begin
      if (paddr == OFS_INT_ST)
        prdata = {29'h0, int_st};
      else if (paddr == OFS_INT_MSK)
        prdata = {29'h0, int_msk};
      else if (paddr < OFS_INT_ST)
      begin
        unique case (sel_ofs)
          OFS_LOAD:  prdata = {16'h0, tmr[sel_idx].load};            // R14
          OFS_VALUE: prdata = {16'h0, tmr[sel_idx].count};           // R14
          OFS_CTRL:  prdata = {30'h0, mode_periodic[sel_idx], tmr[sel_idx].en};
          default:   prdata = RD_ZERO;
        endcase
      end
    end
  end

  chk_load_now: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && paddr == OFS_LOAD) |=> (tmr[0].count == $past(pwdata[CNT_W-1:0])))
    else $error("load did not reach counter");
  chk_wrap_free: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (underflow[0] && !mode_periodic[0] && !wr_en)
      |=> tmr[0].count == CNT_WRAP)
    else $error("free mode did not wrap");
  chk_reload_per: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (underflow[1] && mode_periodic[1] && !wr_en) |=> tmr[1].count == $past(tmr[1].load))
    else $error("periodic mode did not reload");
  chk_irq_same: assert property (@(posedge pclk) disable iff (!presetn) // R8
    underflow[2] |-> tmr_irq[2] ##1 int_st[2])
    else $error("interrupt late");
  chk_clear_irq: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (wr_en && paddr == OFS_CLEAR && !underflow[0]) |=> !int_st[0])
    else $error("clear ignored");
  chk_hold_noedge: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (!tick[0] && !wr_en) |=> $stable(tmr[0].count))
    else $error("count moved without tick");
  chk_idle_unarmed: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (!armed[2] && !wr_en) |=> $stable(tmr[2].count))
    else $error("timer three counted before write");
  chk_dec_one: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (tick[1] && tmr[1].en && armed[1] && tmr[1].count != CNT_ZERO && !wr_en)
      |=> tmr[1].count == $past(tmr[1].count) - 16'h0001)
    else $error("decrement wrong");

  chk_status_set: assert property (@(posedge pclk) disable iff (!presetn) // R8
    underflow[0] |=> int_st[0])
    else $error("underflow did not set status");
  chk_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (int_st[1] && !wr_en) |=> int_st[1])
    else $error("status bit dropped without a write");
  chk_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (wr_en && paddr == OFS_INT_ST && pwdata[2] && !underflow[2]) |=> !int_st[2])
    else $error("status write did not clear");
  chk_clear_second: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (wr_en && g_tmr[1].hit && sel_ofs == OFS_CLEAR && !underflow[1]) |=> !int_st[1])
    else $error("clear register ignored");

  chk_load_keep: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (wr_en && paddr == OFS_LOAD) |=> tmr[0].load == $past(pwdata[CNT_W-1:0]))
    else $error("load value not kept");
  chk_load_second: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && g_tmr[1].hit && sel_ofs == OFS_LOAD) |=> tmr[1].count == $past(pwdata[CNT_W-1:0]))
    else $error("load did not reach second counter");
  chk_arm_fast: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (wr_en && g_tmr[2].hit && sel_ofs == OFS_LOAD) |=> armed[2])
    else $error("timer three not armed by write");
  chk_ctrl_enable: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_en && g_tmr[1].hit && sel_ofs == OFS_CTRL) |=> tmr[1].en == $past(pwdata[CTRL_EN]))
    else $error("control write lost");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (psel && !pwrite) |-> prdata[31:CNT_W] == '0)
    else $error("upper read bits not zero");

  chk_off_hold: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (!tmr[1].en && !wr_en) |=> $stable(tmr[1].count))
    else $error("disabled timer counted");
  chk_sync_slow: assert property (@(posedge pclk) disable iff (!presetn) // R15
    edge_508k |-> $past(tick_508k, SYNC_STAGES))
    else $error("edge without synchronised tick");
  chk_sync_2k: assert property (@(posedge pclk) disable iff (!presetn) // R15
    edge_2k |-> $past(tick_2k, SYNC_STAGES))
    else $error("edge without synchronised tick");
  chk_sync_fast: assert property (@(posedge pclk) disable iff (!presetn) // R15
    edge_7m |-> $past(tick_7m, SYNC_STAGES))
    else $error("edge without synchronised tick");
  chk_edge_once: assert property (@(posedge pclk) disable iff (!presetn) // R15
    edge_508k |=> !edge_508k)
    else $error("tick edge lasted two cycles");
  chk_src_select: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (edge_2k && !edge_508k && !first_slow_timer_sel_slow && !wr_en) |=> $stable(tmr[0].count))
    else $error("wrong tick source counted");
  chk_fast_source: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!edge_7m && !wr_en) |=> $stable(tmr[2].count))
    else $error("timer three counted off its source");
  chk_wrap_fast: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (underflow[2] && !mode_periodic[2] && !wr_en) |=> tmr[2].count == CNT_WRAP)
    else $error("timer three did not wrap");
  chk_reload_fast: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (underflow[2] && mode_periodic[2] && !wr_en) |=> tmr[2].count == $past(tmr[2].load))
    else $error("timer three did not reload");
endmodule : tdc_timers

// [verification/tb_top.sv]
// Self-checking bench for the triple down-counter timers
`timescale 1ns/1ps
module tb_top
  import tdc_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, irq;
  logic [2:0]        tk, tmr_irq;
  logic              s1_slow, s1_per, s2_slow, s2_per;
  int                n_errors, num_checks, cyc;

  tdc_timers u_tdc_timers (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick_508k(tk[0]), .tick_2k(tk[1]), .tick_7m(tk[2]),
    .first_slow_timer_sel_slow(s1_slow), .first_slow_timer_periodic(s1_per),
    .second_slow_timer_sel_slow(s2_slow), .second_slow_timer_periodic(s2_per),
    .tmr_irq(tmr_irq), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0000_0000);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rchk

  // Pulse one tick source, long enough to pass the synchroniser
  task automatic tick(input int i);
    @(posedge pclk);
    tk[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    tk[i] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : tick

  initial
  begin
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tk = 3'b000;
    s1_slow = 1'b0;
    s1_per = 1'b0;
    s2_slow = 1'b1;
    s2_per = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_VALUE, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_LOAD, 32'h0000_0002);
    rchk(OFS_VALUE, 32'h0000_0002);
    tick(1);
    rchk(OFS_VALUE, 32'h0000_0002);
    tick(0);
    rchk(OFS_VALUE, 32'h0000_0001);
    tick(0);
    tick(0);
    rchk(OFS_VALUE, 32'h0000_FFFF);
    @(negedge pclk);
    chk({29'h0, tmr_irq}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, OFS_CLEAR, 32'h0000_005A);
    @(negedge pclk);
    chk({29'h0, tmr_irq}, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    tick(0);
    rchk(OFS_VALUE, 32'h0000_FFFF);
    rchk(OFS_LOAD, 32'h0000_0002);
    apb(1'b1, 8'h28, 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_0001);
    tick(1);
    tick(1);
    rchk(8'h24, 32'h0000_0001);
    tick(0);
    rchk(8'h24, 32'h0000_0001);
    apb(1'b1, 8'h48, 32'h0000_0001);
    tick(2);
    rchk(8'h44, 32'h0000_0000);
    apb(1'b1, 8'h40, 32'h0000_0000);
    tick(2);
    rchk(8'h44, 32'h0000_FFFF);
    rchk(OFS_INT_ST, 32'h0000_0006);
    apb(1'b1, OFS_INT_MSK, 32'h0000_0004);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, OFS_INT_ST, 32'h0000_0004);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({29'h0, tmr_irq}, 32'h0000_0002);
    rchk(8'h7C, 32'h0000_0000);
    apb(1'b1, 8'h2C, 32'h0000_0000);
    @(negedge pclk);
    chk({29'h0, tmr_irq}, 32'h0000_0000);
    rchk(8'h28, 32'h0000_0003);
    apb(1'b1, 8'h48, 32'h0000_0003);
    apb(1'b1, 8'h40, 32'h0001_0001);
    rchk(8'h40, 32'h0000_0001);
    rchk(8'h48, 32'h0000_0003);
    tick(2);
    tick(2);
    rchk(8'h44, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h44, 32'h0000_0000);
    rchk(OFS_INT_ST, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
